// ===== design/bpbc_pkg.sv
package bpbc_pkg;
    // ----------------------------------------------------------------
    // address windows (upper 16 bits of the peripheral bus address, upper 9 for flash)
    // ----------------------------------------------------------------
    localparam logic [15:0] WIN_HEX_LEFT = 16'hce84; // left display
    localparam logic [15:0] WIN_HEX_RIGHT = 16'hce85; // right display
    localparam logic [15:0] WIN_BUZZER = 16'hce86; // buzzer control
    localparam logic [15:0] WIN_NVRAM = 16'hce87; // 32k x 8 nv ram
    localparam logic [15:0] WIN_ROTARY = 16'hce83; // rotary switch
    localparam logic [15:0] WIN_BATTERY = 16'hce88; // battery state
    localparam logic [8:0] WIN_FLASH = 9'h000; // 8 MB flash at 0
    localparam int FLASH_TOP_BIT = 23; // 8 MB = 2^23 bytes

    // ----------------------------------------------------------------
    // battery_backup_state field layout
    // ----------------------------------------------------------------
    localparam int BAT_PRESENT_BIT = 0;
    localparam int BAT_CHARGED_BIT = 1;
    localparam int BAT_DISCHARGED_BIT = 2;
    localparam int BAT_ENABLE_BIT = 3;
    localparam logic BAT_ENABLE_RST = 1'b0; // backup off after reset
    localparam logic BUZZER_RST = 1'b0; // buzzer silent after reset
    localparam logic [7:0] HEX_RST = 8'h00; // display clear

    // ----------------------------------------------------------------
    // bus widths and rates
    // ----------------------------------------------------------------
    localparam int PB_ADDR_W = 32;
    localparam int PB_DATA_W = 16; // widest transfer
    localparam int PB_BYTE_W = 8; // narrow transfer
    localparam int PB_CLK_MHZ = 66; // bus rate, board side
    localparam int SYS_CLK_MHZ = 100; // this logic's clock
    localparam int ROTARY_W = 4; // 16 positions
endpackage

// ===== design/bpbc_cpld.sv
module bpbc_cpld #(
    parameter int ADDR_W = bpbc_pkg::PB_ADDR_W,
    parameter int DATA_W = bpbc_pkg::PB_DATA_W
) (
    input wire logic clock,
    input wire logic sys_rst,
    // primary pci reset, active low
    input wire logic pci_rst_n,
    // debugger reset line, split into its three parts
    input wire logic debugger_board_reset_n_i,
    output logic debugger_board_reset_n_o,
    output logic debugger_board_reset_n_oe,
    // peripheral bus request
    input wire logic pb_req,
    input wire logic pb_we,
    input wire logic pb_wide,
    input wire logic [ADDR_W-1:0] pb_addr,
    input wire logic [DATA_W-1:0] pb_wdata,
    output logic pb_ack,
    output logic [DATA_W-1:0] pb_rdata,
    // chip selects for the memories
    output logic nvram_sel,
    output logic flash_sel,
    output logic flash_wide,
    // board functions
    input wire logic bat_present,
    input wire logic bat_charged,
    input wire logic bat_discharged,
    input wire logic [bpbc_pkg::ROTARY_W-1:0] rotary_pos,
    output logic bat_enable,
    output logic buzzer_on,
    output logic [7:0] hex_left,
    output logic [7:0] hex_right,
    output logic board_rst
);
    import bpbc_pkg::*;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // true when the upper half of the address matches a 64k window
    function automatic logic in_win(input logic [ADDR_W-1:0] a,
                                    input logic [15:0] win);
        in_win = (a[ADDR_W-1:16] == win);
    endfunction

    // ----------------------------------------------------------------
    // reset combine
    // ----------------------------------------------------------------
    logic rst; // any reset source active
    // all three sources are taken as synchronous to clock
    assign rst = sys_rst | ~pci_rst_n
        | ~debugger_board_reset_n_i;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic ack_q, ack_d; // answer strobe
    logic [DATA_W-1:0] rdata_q, rdata_d; // read data
    logic nvram_q, nvram_d; // nv ram select
    logic flash_q, flash_d; // flash select
    logic bat_en_q, bat_en_d; // backup enable bit
    logic buzz_q, buzz_d; // buzzer state
    logic [7:0] hexl_q, hexl_d; // left display
    logic [7:0] hexr_q, hexr_d; // right display
    logic brst_q, brst_d; // board reset out
    logic dbg_oe_q, dbg_oe_d; // drive debugger line
    logic fl_wide_q, fl_wide_d; // flash data path is always 16 bits
    logic dbg_lo_q, dbg_lo_d; // level put on the debug line, held low

    // decoded windows of the current request
    logic hit_l, hit_r, hit_bz, hit_nv, hit_rot, hit_bat, hit_fl;
    logic [7:0] bat_byte; // status as seen by a read

    assign hit_l = in_win(pb_addr, WIN_HEX_LEFT);
    assign hit_r = in_win(pb_addr, WIN_HEX_RIGHT);
    assign hit_bz = in_win(pb_addr, WIN_BUZZER);
    assign hit_nv = in_win(pb_addr, WIN_NVRAM);
    assign hit_rot = in_win(pb_addr, WIN_ROTARY);
    assign hit_bat = in_win(pb_addr, WIN_BATTERY);
    assign hit_fl = (pb_addr[ADDR_W-1:FLASH_TOP_BIT] == WIN_FLASH);

    // status byte; reserved upper nibble reads zero
    always_comb begin
        bat_byte = 8'h00;
        bat_byte[BAT_PRESENT_BIT] = bat_present;
        bat_byte[BAT_CHARGED_BIT] = bat_charged;
        bat_byte[BAT_DISCHARGED_BIT] = bat_discharged;
        bat_byte[BAT_ENABLE_BIT] = bat_en_q;
    end

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    // one request is answered in the following cycle; memories
    // only get their select, the memory itself answers the master
    always_comb begin
        ack_d = 1'b0;
        rdata_d = rdata_q;
        nvram_d = 1'b0;
        flash_d = 1'b0;
        bat_en_d = bat_en_q;
        buzz_d = buzz_q;
        hexl_d = hexl_q;
        hexr_d = hexr_q;
        brst_d = 1'b0;
        dbg_oe_d = ~pci_rst_n; // pass pci reset onto the debug line
        fl_wide_d = 1'b1;
        dbg_lo_d = 1'b0;
        if (pb_req) begin
            nvram_d = hit_nv;
            flash_d = hit_fl;
            // cpld windows answer; unmapped cpld space reads zero
            ack_d = ~(hit_nv | hit_fl);
            rdata_d = '0;
            if (pb_we) begin
                // writes of either width use the low byte lane only
                if (hit_l) begin
                    hexl_d = pb_wdata[7:0];
                end
                if (hit_r) begin
                    hexr_d = pb_wdata[7:0];
                end
                if (hit_bz) begin
                    buzz_d = pb_wdata[0];
                end
                if (hit_bat) begin
                    // read-only and reserved bits are dropped
                    bat_en_d = pb_wdata[BAT_ENABLE_BIT];
                end
            end else begin
                if (hit_rot) begin
                    rdata_d[ROTARY_W-1:0] = rotary_pos;
                end
                if (hit_bat) begin
                    rdata_d[7:0] = bat_byte;
                end
                if (hit_l) begin
                    rdata_d[7:0] = hexl_q;
                end
                if (hit_r) begin
                    rdata_d[7:0] = hexr_q;
                end
                if (hit_bz) begin
                    rdata_d[0] = buzz_q;
                end
                // upper lane is meaningless on a narrow read
                if (!pb_wide) begin
                    rdata_d[DATA_W-1:8] = '0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    // any reset source clears all but fl_wide_q, dbg_oe_q and brst_q; board reset stays high
    // while a source is active so the rest of the board follows
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
            nvram_q <= 1'b0;
            flash_q <= 1'b0;
            bat_en_q <= BAT_ENABLE_RST;
            buzz_q <= BUZZER_RST;
            hexl_q <= HEX_RST;
            hexr_q <= HEX_RST;
            brst_q <= 1'b1;
            dbg_oe_q <= ~pci_rst_n;
            fl_wide_q <= 1'b1;
            dbg_lo_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            nvram_q <= nvram_d;
            flash_q <= flash_d;
            bat_en_q <= bat_en_d;
            buzz_q <= buzz_d;
            hexl_q <= hexl_d;
            hexr_q <= hexr_d;
            brst_q <= brst_d;
            dbg_oe_q <= dbg_oe_d;
            fl_wide_q <= fl_wide_d;
            dbg_lo_q <= dbg_lo_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign pb_ack = ack_q;
    assign pb_rdata = rdata_q;
    assign nvram_sel = nvram_q;
    assign flash_sel = flash_q;
    assign flash_wide = fl_wide_q;
    assign bat_enable = bat_en_q;
    assign buzzer_on = buzz_q;
    assign hex_left = hexl_q;
    assign hex_right = hexr_q;
    assign board_rst = brst_q;
    // open-drain style: only ever pulls low
    assign debugger_board_reset_n_o = dbg_lo_q;
    assign debugger_board_reset_n_oe = dbg_oe_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_bat_bits;
        @(posedge clock) disable iff (rst)
        pb_req && !pb_we && hit_bat |=> pb_rdata[2:0] ==
            {$past(bat_discharged), $past(bat_charged), $past(bat_present)}
            && pb_rdata[7:4] == 4'h0;
    endproperty
    a_bat_bits: assert property (p_bat_bits)
        else $error("battery status bits wrong");

    property p_bat_en;
        @(posedge clock) disable iff (rst)
        pb_req && hit_bat |=> $past(pb_we)
            ? bat_enable == $past(pb_wdata[BAT_ENABLE_BIT])
            : pb_rdata[BAT_ENABLE_BIT] == $past(bat_enable);
    endproperty
    a_bat_en: assert property (p_bat_en)
        else $error("battery enable not read back");

    property p_bat_ro;
        @(posedge clock) disable iff (rst)
        !(pb_req && pb_we && hit_bat) |=> $stable(bat_enable);
    endproperty
    a_bat_ro: assert property (p_bat_ro)
        else $error("battery enable changed without write");

    property p_nvram;
        @(posedge clock) disable iff (rst)
        pb_req && hit_nv |=> nvram_sel && !pb_ack;
    endproperty
    a_nvram: assert property (p_nvram)
        else $error("nv ram not selected");

    property p_buzz;
        @(posedge clock) disable iff (rst)
        pb_req && pb_we && hit_bz |=> buzzer_on == $past(pb_wdata[0]);
    endproperty
    a_buzz: assert property (p_buzz)
        else $error("buzzer did not follow write");

    property p_left;
        @(posedge clock) disable iff (rst)
        pb_req && pb_we && hit_l |=> hex_left == $past(pb_wdata[7:0])
            && $stable(hex_right);
    endproperty
    a_left: assert property (p_left)
        else $error("left display wrong");

    property p_right;
        @(posedge clock) disable iff (rst)
        pb_req && pb_we && hit_r |=> hex_right == $past(pb_wdata[7:0])
            && $stable(hex_left);
    endproperty
    a_right: assert property (p_right)
        else $error("right display wrong");

    property p_rot;
        @(posedge clock) disable iff (rst)
        pb_req && !pb_we && hit_rot |=> pb_ack
            && pb_rdata == {12'h000, $past(rotary_pos)};
    endproperty
    a_rot: assert property (p_rot)
        else $error("rotary read wrong");

    property p_narrow;
        @(posedge clock) disable iff (rst)
        pb_req && !pb_we && !pb_wide |=> pb_rdata[15:8] == 8'h00;
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("narrow read upper lane not zero");

    property p_pci_rst;
        @(posedge clock) !pci_rst_n |=> board_rst && !buzzer_on
            && !bat_enable && hex_left == 8'h00 ##1 debugger_board_reset_n_oe
            || pci_rst_n;
    endproperty
    a_pci_rst: assert property (p_pci_rst)
        else $error("pci reset did not clear state");

    property p_dbg_rst;
        @(posedge clock) !debugger_board_reset_n_i |=> board_rst;
    endproperty
    a_dbg_rst: assert property (p_dbg_rst)
        else $error("debugger reset ignored");

    c_left: cover property (@(posedge clock) pb_req && pb_we && hit_l);
    c_bat_rd: cover property (@(posedge clock) pb_req && !pb_we && hit_bat);
    c_rot_rd: cover property (@(posedge clock) pb_req && !pb_we && hit_rot);
    c_dbg: cover property (@(posedge clock) !debugger_board_reset_n_i);
endmodule

// ===== test/bpbc_pb_master.sv
// ----------------------------------------------------------------
// peripheral bus controller model, issues one request per call
// ----------------------------------------------------------------
module bpbc_pb_master (
    input wire logic clock,
    output logic pb_req,
    output logic pb_we,
    output logic pb_wide,
    output logic [31:0] pb_addr,
    output logic [15:0] pb_wdata,
    input wire logic pb_ack,
    input wire logic [15:0] pb_rdata,
    input wire logic nvram_sel,
    input wire logic flash_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus, nothing requested
    initial begin
        pb_req = 1'b0;
        pb_we = 1'b0;
        pb_wide = 1'b0;
        pb_addr = 32'h0000_0000;
        pb_wdata = 16'h0000;
    end
    // one-cycle request, answer looked at one cycle after it is taken
    task automatic access(input logic we, input logic wide,
        input logic [31:0] addr, input logic [15:0] wdata,
        output logic [15:0] rdata, output logic [2:0] resp);
        @(posedge clock);
        pb_req <= 1'b1;
        pb_we <= we;
        pb_wide <= wide;
        pb_addr <= addr;
        pb_wdata <= wdata;
        @(posedge clock);
        pb_req <= 1'b0;
        // released lines show no stale value
        pb_addr <= ~addr;
        pb_wdata <= ~wdata;
        @(posedge clock);
        rdata = pb_rdata;
        resp = {pb_ack, nvram_sel, flash_sel};
    endtask
endmodule

// ===== test/board_peripheral_bus_cpld_tb.sv
// ----------------------------------------------------------------
// self-checking bench for the board logic
// ----------------------------------------------------------------
module board_peripheral_bus_cpld_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bpbc_pkg::*;
    logic clock, sys_rst, pci_rst_n, dbg_pull_n;
    logic bat_present, bat_charged, bat_discharged;
    logic [3:0] rotary_pos;
    logic pb_req, pb_we, pb_wide, pb_ack;
    logic [31:0] pb_addr, r;
    logic [15:0] pb_wdata, pb_rdata, rd;
    logic nvram_sel, flash_sel, flash_wide, bat_enable, buzzer_on;
    logic board_rst, dbg_o, dbg_oe;
    logic [7:0] hex_left, hex_right, hl, hr;
    logic [2:0] rsp;
    int miscompares, check_count, seed;
    wire dbg_line;
    // open-drain debug reset line with pull-up
    assign dbg_line = (dbg_oe && !dbg_o) ? 1'b0 : dbg_pull_n;
    bpbc_cpld i_bpbc_cpld (.clock(clock), .sys_rst(sys_rst),
        .pci_rst_n(pci_rst_n), .debugger_board_reset_n_i(dbg_line),
        .debugger_board_reset_n_o(dbg_o),
        .debugger_board_reset_n_oe(dbg_oe), .pb_req(pb_req),
        .pb_we(pb_we), .pb_wide(pb_wide), .pb_addr(pb_addr),
        .pb_wdata(pb_wdata), .pb_ack(pb_ack), .pb_rdata(pb_rdata),
        .nvram_sel(nvram_sel), .flash_sel(flash_sel),
        .flash_wide(flash_wide), .bat_present(bat_present),
        .bat_charged(bat_charged), .bat_discharged(bat_discharged),
        .rotary_pos(rotary_pos), .bat_enable(bat_enable),
        .buzzer_on(buzzer_on), .hex_left(hex_left),
        .hex_right(hex_right), .board_rst(board_rst));
    bpbc_pb_master i_bpbc_pb_master (.clock(clock), .pb_req(pb_req),
        .pb_we(pb_we), .pb_wide(pb_wide), .pb_addr(pb_addr),
        .pb_wdata(pb_wdata), .pb_ack(pb_ack), .pb_rdata(pb_rdata),
        .nvram_sel(nvram_sel), .flash_sel(flash_sel));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus call; the answer lands in rd and rsp
    task automatic xfer(input logic we, input logic wide,
        input logic [31:0] addr, input logic [15:0] wdata);
        i_bpbc_pb_master.access(we, wide, addr, wdata, rd, rsp);
    endtask
    // status byte, reserved upper bits read zero
    function automatic logic [15:0] bat_exp(input logic en);
        return {12'h000, en, bat_discharged, bat_charged, bat_present};
    endfunction
    task automatic close_out();
        if (miscompares == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // watchdog, well beyond the expected run
    initial begin
        #200000;
        miscompares++;
        close_out();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 92639;
        miscompares = 0;
        check_count = 0;
        {sys_rst, pci_rst_n, dbg_pull_n} = 3'b111;
        {bat_present, bat_charged, bat_discharged} = 3'b000;
        rotary_pos = 4'h0;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        chk({13'h0, bat_enable, buzzer_on, board_rst}, 16'h0);
        chk({hex_left, hex_right}, 16'h0000);
        // every switch position, narrow and wide reads alternate
        for (int i = 0; i < 16; i++) begin
            rotary_pos <= i[3:0];
            xfer(1'b0, i[0], {WIN_ROTARY, 16'h0004}, 16'h0);
            chk(rd, {12'h000, i[3:0]});
            chk(16'(rsp), 16'h4);
        end
        // random status inputs, random writes to every status bit
        repeat (8) begin
            r = $random(seed);
            {bat_present, bat_charged, bat_discharged} <= r[10:8];
            xfer(1'b1, 1'b0, {WIN_BATTERY, r[15:0]}, r[15:0]);
            chk(16'(bat_enable), 16'(r[3]));
            xfer(1'b0, 1'b1, {WIN_BATTERY, 16'h0}, 16'h0);
            chk(rd, bat_exp(r[3]));
        end
        // displays latch independently, left one read back its byte
        {hl, hr} = 16'h0000;
        repeat (8) begin
            r = $random(seed);
            hl = r[7:0];
            xfer(1'b1, r[16], {WIN_HEX_LEFT, r[31:16]}, r[15:0]);
            chk({hex_left, hex_right}, {hl, hr});
            hr = r[15:8];
            xfer(1'b1, 1'b0, {WIN_HEX_RIGHT, r[15:0]}, {8'h00, hr});
            chk({hex_left, hex_right}, {hl, hr});
            xfer(1'b0, 1'b1, {WIN_HEX_LEFT, 16'hfffe}, 16'h0);
            chk(rd, {8'h00, hl});
        end
        // buzzer on then off, read back at bit 0
        for (int b = 1; b >= 0; b--) begin
            xfer(1'b1, 1'b0, {WIN_BUZZER, 16'hffff}, {15'h0, b[0]});
            chk({15'h0, buzzer_on}, {15'h0, b[0]});
            chk(16'(rsp), 16'h4);
            xfer(1'b0, 1'b0, {WIN_BUZZER, 16'h0000}, 16'h0);
            chk(rd, {15'h0, b[0]});
        end
        // window edges of the nv ram, random offsets between
        foreach (hl[i]) begin
            r = (i < 2) ? {16'hce87, {16{i[0]}}}
                : {16'hce87, 16'($random(seed))};
            xfer(r[0], 1'b0, r, 16'h00a5);
            chk(16'(rsp), 16'h2);
        end
        // flash at both ends, then the first address above it
        xfer(1'b0, 1'b1, 32'h0000_0000, 16'h0);
        chk({13'h0, rsp}, 16'h1);
        xfer(1'b0, 1'b1, 32'h007f_fffe, 16'h0);
        chk({13'h0, rsp}, 16'h1);
        chk({15'h0, flash_wide}, 16'h1);
        xfer(1'b0, 1'b1, 32'h0080_0000, 16'h0);
        chk({13'h0, rsp}, 16'h4);
        chk(rd, 16'h0000);
        // backup on before reset, so that the clear is visible
        xfer(1'b1, 1'b0, {WIN_BATTERY, 16'h0}, 16'h0008);
        chk(16'(bat_enable), 16'h1);
        // primary reset pulls the debug line and clears the displays, buzzer and backup enable
        pci_rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        chk({14'h0, dbg_oe, dbg_o}, 16'h2);
        chk({15'h0, board_rst}, 16'h1);
        pci_rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        chk({13'h0, bat_enable, buzzer_on, board_rst}, 16'h0);
        chk({hex_left, hex_right}, 16'h0000);
        // debugger pulls the line low from outside
        xfer(1'b1, 1'b0, {WIN_HEX_LEFT, 16'h0}, 16'h005a);
        chk({8'h00, hex_left}, 16'h005a);
        dbg_pull_n <= 1'b0;
        repeat (2) @(posedge clock);
        chk({15'h0, board_rst}, 16'h1);
        dbg_pull_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk({board_rst, 7'h0, hex_left}, 16'h0);
        close_out();
    end
endmodule
